// >>> core/lfs_pkg.sv
// Shared constants, types and lookup functions of the lock fault bank.
package lfs_pkg;

  // Register offsets on the host register port.
  localparam logic [7:0] LFS_OFS_FAULT_SETUP = 8'h90;
  localparam logic [7:0] LFS_OFS_SPEED_PTS   = 8'h9C;
  localparam logic [7:0] LFS_OFS_OFF_CLAMP   = 8'h9E;

  // Reset values of the three registers.
  localparam logic [31:0] LFS_RST_FAULT_SETUP = 32'h0000_0000;
  localparam logic [31:0] LFS_RST_SPEED_PTS   = 32'h0000_0000;
  localparam logic [31:0] LFS_RST_OFF_CLAMP   = 32'h0000_0000;

  // Field positions (least significant bit) of the speed registers.
  localparam int LFS_SPB_LSB    = 30;
  localparam int LFS_SPC_LSB    = 22;
  localparam int LFS_SPD_LSB    = 14;
  localparam int LFS_SPE_LSB    = 6;
  localparam int LFS_OFF2_LSB   = 23;
  localparam int LFS_CLAMP2_LSB = 15;

  // Field positions of the fault setup register.
  localparam int LFS_TORQ_LSB  = 27;
  localparam int LFS_CMP_LSB   = 23;
  localparam int LFS_SMP_LSB   = 19;
  localparam int LFS_RESP_LSB  = 15;
  localparam int LFS_DEG_LSB   = 11;
  localparam int LFS_RETRY_LSB = 7;
  localparam int LFS_TMO_BIT   = 2;
  localparam int LFS_FRQ_BIT   = 1;
  localparam int LFS_SAT_BIT   = 0;

  // Timing base: one tick is 0.05 ms at a 10 ns clock.
  localparam int LFS_CLK_PERIOD_NS = 10;
  localparam int LFS_TICK_TIME_NS  = 50000;
  localparam int LFS_TICK_CYCLES   = LFS_TICK_TIME_NS / LFS_CLK_PERIOD_NS;

  // Response code landmarks.
  localparam logic [3:0] LFS_RESP_LATCH_MAX = 4'h3;
  localparam logic [3:0] LFS_RESP_RETRY_HS  = 4'h6;
  localparam logic [3:0] LFS_RESP_REPORT    = 4'h8;

  // Output stage action.
  typedef enum logic [2:0] {
    LFS_BR_DRIVE  = 3'b000,
    LFS_BR_TRI    = 3'b001,
    LFS_BR_RECIRC = 3'b010,
    LFS_BR_HS     = 3'b011,
    LFS_BR_LS     = 3'b100
  } lfs_bridge_t;

  // Lock supervisor states.
  typedef enum logic [1:0] {
    LFS_ST_WATCH   = 2'b00,
    LFS_ST_RETRY   = 2'b01,
    LFS_ST_LATCHED = 2'b10,
    LFS_ST_REPORT  = 2'b11
  } lfs_state_t;

  // Decoded configuration handed to the control algorithm.
  typedef struct packed {
    logic       speed_point_b_lsb;
    logic [7:0] speed_point_c;
    logic [7:0] speed_point_d;
    logic [7:0] speed_point_e;
    logic [7:0] second_turn_off_speed;
    logic [7:0] second_clamp_speed;
    logic [3:0] torque_current_reference;
    logic [3:0] comparator_lock_threshold;
    logic [3:0] sampled_lock_threshold;
    logic [3:0] current_lock_response;
    logic [3:0] current_lock_deglitch;
    logic [3:0] lock_retry_interval;
    logic       startup_position_timeout_enable;
    logic       startup_position_frequency_enable;
    logic       saturation_indication_enable;
  } lfs_cfg_t;

  // Deglitch time in ticks for each code.
  function automatic logic [19:0] lfs_deg_ticks(input logic [3:0] code);
    logic [19:0] t;
    t = 20'h00001;
    unique case (code)
      4'h0: t = 20'h00001;
      4'h1: t = 20'h00002;
      4'h2: t = 20'h00004;
      4'h3: t = 20'h0000A;
      4'h4: t = 20'h00014;
      4'h5: t = 20'h00032;
      4'h6: t = 20'h00064;
      4'h7: t = 20'h00096;
      4'h8: t = 20'h000C8;
      4'h9: t = 20'h001F4;
      4'hA: t = 20'h003E8;
      4'hB: t = 20'h005DC;
      4'hC: t = 20'h007D0;
      4'hD: t = 20'h00FA0;
      4'hE: t = 20'h02710;
      4'hF: t = 20'h04E20;
    endcase
    return t;
  endfunction : lfs_deg_ticks

  // Retry interval in ticks; the reserved code behaves as 500 ms.
  function automatic logic [19:0] lfs_retry_ticks(input logic [3:0] code);
    logic [19:0] t;
    if (code <= 4'h1) begin
      t = 20'h02710;
    end else begin
      t = 20'(({16'h0, code} - 20'h1) * 20'h04E20);
    end
    return t;
  endfunction : lfs_retry_ticks

  // Brake action for a response code; low two bits pick it.
  function automatic lfs_bridge_t lfs_brake(input logic [3:0] code);
    lfs_bridge_t b;
    unique case (code[1:0])
      2'b00: b = LFS_BR_TRI;
      2'b01: b = LFS_BR_RECIRC;
      2'b10: b = LFS_BR_HS;
      2'b11: b = LFS_BR_LS;
    endcase
    return b;
  endfunction : lfs_brake

endpackage : lfs_pkg

// >>> core/lfs_lock_fault_cfg.sv
// Speed profile and current lock fault configuration bank with supervisor.
//
// Notes on behaviour
// - Speed B low bit at bit 30.
// - Speed C in bits 29 to 22.
// - Speed D in bits 21 to 14.
// - Speed E bits 13-6, low bits reset zero.
// - Second turn-off speed in bits 30-23.
// - Second clamp speed bits 22-15, rest reserved.
// - Torque current reference in bits 30-27.
// - Comparator lock threshold in bits 26-23.
// - Sampled lock threshold in bits 22-19.
// - Codes 0-3 latch fault with chosen brake.
// - Codes 4,5,7 retry, then latch with brake.
// - Code 6 retries holding high-side brake.
// - Code 8 reports only, no stage action.
// - Codes 9 to F disable lock detection.
// - Over-limit must persist the deglitch time.
// - Retry interval from bits 10-7.
// - Bit 0 enables saturation indication.
// - Bits 2 and 1 enable startup faults.
`timescale 1ns/100ps

module lfs_lock_fault_cfg
  import lfs_pkg::*;
#(
  parameter int TICK_CYCLES = LFS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Host register port.
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output      logic [31:0] reg_rdata,
  // Lock detection inputs.
  input  wire logic        lock_over_limit,
  input  wire logic        fault_clear,
  input  wire logic [2:0]  auto_retry_limit,
  // Configuration and fault outputs.
  output      lfs_cfg_t    cfg,
  output      logic        fault_output_pin_n,
  output      lfs_bridge_t bridge_mode,
  output      logic        fault_latched
);

  // Register storage, all bits kept including reserved ones.
  logic [31:0] setup_q, setup_d;     // Fault setup register.
  logic [31:0] spd_q, spd_d;         // Speed points B to E.
  logic [31:0] offc_q, offc_d;       // Second turn-off and clamp.
  logic [31:0] rdata_q, rdata_d;     // Read data holding register.
  logic        setup_wr;             // Write strobe to fault setup.

  // Register write and read decode.
  always_comb begin
    setup_d  = setup_q;
    spd_d    = spd_q;
    offc_d   = offc_q;
    rdata_d  = rdata_q;
    setup_wr = reg_wr_en && (reg_addr == LFS_OFS_FAULT_SETUP);
    // Writes to unlisted offsets are dropped.
    if (setup_wr) begin
      setup_d = reg_wdata;
    end
    if (reg_wr_en && (reg_addr == LFS_OFS_SPEED_PTS)) begin
      spd_d = reg_wdata;
    end
    if (reg_wr_en && (reg_addr == LFS_OFS_OFF_CLAMP)) begin
      offc_d = reg_wdata;
    end
    // A read loads the holding register; unmapped reads give zero.
    if (reg_rd_en) begin
      unique case (reg_addr)
        LFS_OFS_FAULT_SETUP: rdata_d = setup_q;
        LFS_OFS_SPEED_PTS:   rdata_d = spd_q;
        LFS_OFS_OFF_CLAMP:   rdata_d = offc_q;
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register update.
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_q <= LFS_RST_FAULT_SETUP;
      spd_q   <= LFS_RST_SPEED_PTS;
      offc_q  <= LFS_RST_OFF_CLAMP;
      rdata_q <= 32'h0000_0000;
    end else begin
      setup_q <= setup_d;
      spd_q   <= spd_d;
      offc_q  <= offc_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Field slicing straight off the register flip-flops.
  always_comb begin
    cfg.speed_point_b_lsb         = spd_q[LFS_SPB_LSB];
    cfg.speed_point_c             = spd_q[LFS_SPC_LSB+:8];
    cfg.speed_point_d             = spd_q[LFS_SPD_LSB+:8];
    cfg.speed_point_e             = spd_q[LFS_SPE_LSB+:8];
    cfg.second_turn_off_speed     = offc_q[LFS_OFF2_LSB+:8];
    cfg.second_clamp_speed        = offc_q[LFS_CLAMP2_LSB+:8];
    cfg.torque_current_reference  = setup_q[LFS_TORQ_LSB+:4];
    cfg.comparator_lock_threshold = setup_q[LFS_CMP_LSB+:4];
    cfg.sampled_lock_threshold    = setup_q[LFS_SMP_LSB+:4];
    cfg.current_lock_response     = setup_q[LFS_RESP_LSB+:4];
    cfg.current_lock_deglitch     = setup_q[LFS_DEG_LSB+:4];
    cfg.lock_retry_interval       = setup_q[LFS_RETRY_LSB+:4];
    cfg.startup_position_timeout_enable   = setup_q[LFS_TMO_BIT];
    cfg.startup_position_frequency_enable = setup_q[LFS_FRQ_BIT];
    cfg.saturation_indication_enable      = setup_q[LFS_SAT_BIT];
  end

  // Supervisor state.
  lfs_state_t  state_q, state_d;     // Lock supervisor state.
  logic [15:0] presc_q, presc_d;     // Clock cycles within a tick.
  logic [19:0] ticks_q, ticks_d;     // Ticks in the current wait.
  logic [2:0]  tries_q, tries_d;     // Auto-retry attempts used.
  logic        pin_n_q, pin_n_d;     // Fault pin, low when active.
  lfs_bridge_t bridge_q, bridge_d;   // Output stage action.
  logic        latch_q, latch_d;     // Latched fault status.
  logic        tick;                 // Last cycle of a tick.
  logic [3:0]  resp;                 // Current response code.

  // Next state of the lock supervisor.
  always_comb begin
    resp    = setup_q[LFS_RESP_LSB+:4];
    tick    = (presc_q == 16'(TICK_CYCLES - 1));
    state_d = state_q;
    tries_d = tries_q;
    presc_d = tick ? 16'h0000 : presc_q + 16'h0001;
    ticks_d = ticks_q + {19'h00000, tick};
    unique case (state_q)
      // Watch the over-limit input for the deglitch time.
      LFS_ST_WATCH: begin
        if (!lock_over_limit || (resp > LFS_RESP_REPORT)) begin
          // Glitch ended or detection disabled: restart timing.
          presc_d = 16'h0000;
          ticks_d = 20'h00000;
        end else if (ticks_q >= lfs_deg_ticks(setup_q[LFS_DEG_LSB+:4])) begin
          presc_d = 16'h0000;
          ticks_d = 20'h00000;
          if (resp <= LFS_RESP_LATCH_MAX) begin
            state_d = LFS_ST_LATCHED;
          end else if (resp == LFS_RESP_REPORT) begin
            state_d = LFS_ST_REPORT;
          end else if (tries_q >= auto_retry_limit) begin
            state_d = LFS_ST_LATCHED;
          end else begin
            state_d = LFS_ST_RETRY;
            tries_d = tries_q + 3'h1;
          end
        end
      end
      // Hold the fault for the retry interval, then clear it.
      LFS_ST_RETRY: begin
        if (ticks_q >= lfs_retry_ticks(setup_q[LFS_RETRY_LSB+:4])) begin
          state_d = LFS_ST_WATCH;
          presc_d = 16'h0000;
          ticks_d = 20'h00000;
        end
      end
      // Latched or reported faults wait for software.
      LFS_ST_LATCHED, LFS_ST_REPORT: begin
        presc_d = 16'h0000;
        ticks_d = 20'h00000;
      end
    endcase
    // Software clear releases any held fault.
    if (fault_clear && (state_q != LFS_ST_WATCH)) begin
      state_d = LFS_ST_WATCH;
      presc_d = 16'h0000;
      ticks_d = 20'h00000;
    end
    // Attempt counter restarts on latch, clear or setup write.
    if (fault_clear || setup_wr || (state_d == LFS_ST_LATCHED)) begin
      tries_d = 3'h0;
    end
    // Pin and stage follow the next state.
    pin_n_d = (state_d == LFS_ST_WATCH);
    latch_d = (state_d == LFS_ST_LATCHED);
    if ((state_d == LFS_ST_WATCH) || (state_d == LFS_ST_REPORT)) begin
      bridge_d = LFS_BR_DRIVE;
    end else begin
      bridge_d = lfs_brake(resp);
    end
  end

  // Supervisor registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= LFS_ST_WATCH;
      presc_q  <= 16'h0000;
      ticks_q  <= 20'h00000;
      tries_q  <= 3'h0;
      pin_n_q  <= 1'b1;
      bridge_q <= LFS_BR_DRIVE;
      latch_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      presc_q  <= presc_d;
      ticks_q  <= ticks_d;
      tries_q  <= tries_d;
      pin_n_q  <= pin_n_d;
      bridge_q <= bridge_d;
      latch_q  <= latch_d;
    end
  end

  assign fault_output_pin_n = pin_n_q;
  assign bridge_mode        = bridge_q;
  assign fault_latched      = latch_q;

  // Checks of the register bank and the supervisor.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Speed B low bit follows a write.
  AST_SPEED_B: assert property (
    reg_wr_en && reg_addr == LFS_OFS_SPEED_PTS |=>
    cfg.speed_point_b_lsb == $past(reg_wdata[30]))
    else $error("speed B low bit wrong");

  // Speed C, D and E follow a write.
  AST_SPEED_CDE: assert property (
    reg_wr_en && reg_addr == LFS_OFS_SPEED_PTS |=>
    {cfg.speed_point_c, cfg.speed_point_d, cfg.speed_point_e}
      == $past(reg_wdata[29:6]))
    else $error("speed points C to E wrong");

  // Second turn-off and clamp speeds follow a write.
  AST_OFF_CLAMP: assert property (
    reg_wr_en && reg_addr == LFS_OFS_OFF_CLAMP |=>
    {cfg.second_turn_off_speed, cfg.second_clamp_speed}
      == $past(reg_wdata[30:15]))
    else $error("second speeds wrong");

  // Fault setup reads back exactly what was written.
  AST_SETUP_READBACK: assert property (
    (reg_wr_en && reg_addr == LFS_OFS_FAULT_SETUP) ##1
    (reg_rd_en && !reg_wr_en && reg_addr == LFS_OFS_FAULT_SETUP) |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("fault setup readback wrong");

  // A latched fault under codes 0-3 drives the pin and brake.
  AST_LATCH_ACTION: assert property (
    $rose(fault_latched) && resp <= LFS_RESP_LATCH_MAX |->
    !fault_output_pin_n && bridge_mode == lfs_brake(resp))
    else $error("latched action wrong");

  // A latched fault holds until software clears it.
  AST_LATCH_HOLD: assert property (
    fault_latched && !fault_clear |=> fault_latched)
    else $error("latched fault released");

  // Report mode leaves the stage driving.
  AST_REPORT_ONLY: assert property (
    state_q == LFS_ST_REPORT |->
    !fault_output_pin_n && bridge_mode == LFS_BR_DRIVE)
    else $error("report mode acted on stage");

  // Disabled codes never leave the watch state.
  AST_DISABLED: assert property (
    state_q == LFS_ST_WATCH && resp > LFS_RESP_REPORT && !setup_wr |=>
    state_q == LFS_ST_WATCH && fault_output_pin_n)
    else $error("disabled detection fired");

  // A fault is only declared after over-limit was seen.
  AST_DEGLITCH: assert property (
    $fell(fault_output_pin_n) |-> $past(lock_over_limit))
    else $error("fault without over-limit");

  // Code 6 retry holds the high-side brake.
  AST_RETRY_HS: assert property (
    state_q == LFS_ST_RETRY && resp == LFS_RESP_RETRY_HS |->
    bridge_mode == LFS_BR_HS)
    else $error("code 6 brake wrong");

  // Software clear empties the attempt counter.
  AST_TRIES_CLEAR: assert property (
    fault_clear |=> tries_q == 3'h0)
    else $error("retry counter not cleared");

  // A declared fault needs the over-limit seen two samples before the pin drops.
  AST_DEG_HOLD: assert property (
    $fell(fault_output_pin_n) |-> $past(lock_over_limit, 2))
    else $error("fault declared before deglitch");

  // A rewrite of the fault setup empties the attempt counter.
  AST_TRIES_REWRITE: assert property (
    setup_wr |=> tries_q == 3'h0)
    else $error("retry counter kept after rewrite");

endmodule : lfs_lock_fault_cfg

// >>> tb/lfs_tb.sv
// Self-checking testbench for the lock fault configuration bank.
`timescale 1ns/100ps

module tb;
  import lfs_pkg::*;

  // Clock, reset and host register port.
  logic        clk;
  logic        rst;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  // Lock detection inputs and design outputs.
  logic        lock_over_limit;
  logic        fault_clear;
  logic [2:0]  auto_retry_limit;
  lfs_cfg_t    cfg;
  logic        fault_output_pin_n;
  lfs_bridge_t bridge_mode;
  logic        fault_latched;
  // Result counters.
  int          err_count;
  int          compares;
  // Expected brake per low two bits of the response code.
  lfs_bridge_t brk [4] = '{LFS_BR_TRI, LFS_BR_RECIRC, LFS_BR_HS, LFS_BR_LS};

  // A short tick keeps lock timing within a brief run.
  lfs_lock_fault_cfg #(.TICK_CYCLES(4)) lfs_lock_fault_cfg_inst (
    .clk(clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lock_over_limit(lock_over_limit), .fault_clear(fault_clear),
    .auto_retry_limit(auto_retry_limit), .cfg(cfg),
    .fault_output_pin_n(fault_output_pin_n), .bridge_mode(bridge_mode),
    .fault_latched(fault_latched)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Compares one value and reports any difference at once.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One register write; an idle cycle follows so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  // One register read, judged once the registered data has landed.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask : rd

  // A write followed at once by a read of the same offset.
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
    chk("wr_rd", d, reg_rdata);
  endtask : wr_rd

  // Holds an over-limit until the pin drops; returns the cycles taken.
  task automatic trip(output int n);
    lock_over_limit = 1'b1;
    n = 0;
    while (fault_output_pin_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    lock_over_limit = 1'b0;
    if (n >= 200) begin
      err_count++;
      $display("mismatch fault_pin expected 0 seen %b", fault_output_pin_n);
      wrap_up();
    end
  endtask : trip

  // Pulses the software clear and checks the outputs went idle.
  task automatic clr;
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    @(negedge clk);
    chk("pin_idle", 32'h1, 32'(fault_output_pin_n));
    chk("bridge_idle", 32'(LFS_BR_DRIVE), 32'(bridge_mode));
  endtask : clr

  // All three registers and the configuration come out of reset at zero, with the pin high.
  task automatic s_reset;
    chk("cfg_zero", 32'h1, 32'(cfg === '0));
    chk("pin", 32'h1, 32'(fault_output_pin_n));
    rd(LFS_OFS_FAULT_SETUP, 32'h0000_0000);
    rd(LFS_OFS_SPEED_PTS, 32'h0000_0000);
    rd(LFS_OFS_OFF_CLAMP, 32'h0000_0000);
  endtask : s_reset

  // Fault setup fields decode from their bit slices and read back whole.
  task automatic s_fault_reg;
    logic [31:0] w;
    w = 32'hF5A3_4C87;
    wr(LFS_OFS_FAULT_SETUP, w);
    chk("torq", 32'(w[30:27]), 32'(cfg.torque_current_reference));
    chk("cmp", 32'(w[26:23]), 32'(cfg.comparator_lock_threshold));
    chk("smp", 32'(w[22:19]), 32'(cfg.sampled_lock_threshold));
    chk("resp", 32'(w[18:15]), 32'(cfg.current_lock_response));
    chk("deg", 32'(w[14:11]), 32'(cfg.current_lock_deglitch));
    chk("retry", 32'(w[10:7]), 32'(cfg.lock_retry_interval));
    chk("tmo", 32'(w[2]), 32'(cfg.startup_position_timeout_enable));
    chk("frq", 32'(w[1]), 32'(cfg.startup_position_frequency_enable));
    chk("sat", 32'(w[0]), 32'(cfg.saturation_indication_enable));
    rd(LFS_OFS_FAULT_SETUP, w);
    // The host only reads the unlisted offset, never writes it.
    rd(8'h92, 32'h0000_0000);
    rd(LFS_OFS_FAULT_SETUP, w);
    wr_rd(LFS_OFS_FAULT_SETUP, ~w);
  endtask : s_fault_reg

  // Speed profile fields land in their assigned slices.
  task automatic s_speed;
    logic [31:0] w;
    logic [31:0] v;
    w = 32'hC3A5_96FF;
    v = 32'hB4E1_7ABC;
    wr(LFS_OFS_SPEED_PTS, w);
    wr(LFS_OFS_OFF_CLAMP, v);
    chk("spb", 32'(w[30]), 32'(cfg.speed_point_b_lsb));
    chk("spc", 32'(w[29:22]), 32'(cfg.speed_point_c));
    chk("spd", 32'(w[21:14]), 32'(cfg.speed_point_d));
    chk("spe", 32'(w[13:6]), 32'(cfg.speed_point_e));
    chk("off2", 32'(v[30:23]), 32'(cfg.second_turn_off_speed));
    chk("clamp2", 32'(v[22:15]), 32'(cfg.second_clamp_speed));
    rd(LFS_OFS_SPEED_PTS, w);
    rd(LFS_OFS_OFF_CLAMP, v);
  endtask : s_speed

  // Latching codes, and retry codes with no retries left, brake and latch.
  task automatic s_latch;
    int n;
    auto_retry_limit = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(LFS_OFS_FAULT_SETUP, {13'h0, 4'(c), 15'h0});
      trip(n);
      chk("brake", 32'(brk[c % 4]), 32'(bridge_mode));
      chk("latched", 32'h1, 32'(fault_latched));
      clr();
      chk("unlatched", 32'h0, 32'(fault_latched));
    end
  endtask : s_latch

  // Report-only code drops the pin but leaves the stage driving.
  task automatic s_report;
    int n;
    wr(LFS_OFS_FAULT_SETUP, 32'h0004_0000);
    trip(n);
    chk("report_bridge", 32'(LFS_BR_DRIVE), 32'(bridge_mode));
    repeat (20) @(negedge clk);
    chk("report_pin", 32'h0, 32'(fault_output_pin_n));
    clr();
  endtask : s_report

  // Disabling codes never react to a long over-limit.
  task automatic s_disabled;
    for (int c = 9; c < 16; c++) begin
      wr(LFS_OFS_FAULT_SETUP, {13'h0, 4'(c), 15'h0});
      lock_over_limit = 1'b1;
      repeat (30) @(negedge clk);
      chk("off_pin", 32'h1, 32'(fault_output_pin_n));
      lock_over_limit = 1'b0;
      @(negedge clk);
    end
  endtask : s_disabled

  // Retry codes brake without latching and a clear rearms the budget;
  // an expired 500 ms wait frees the pin, and the next lock then latches.
  task automatic s_retry;
    int n;
    auto_retry_limit = 3'h1;
    for (int c = 4; c < 8; c++) begin
      wr(LFS_OFS_FAULT_SETUP, {13'h0, 4'(c), 15'h0});
      trip(n);
      chk("retry_brake", 32'(brk[c % 4]), 32'(bridge_mode));
      chk("retry_latch", 32'h0, 32'(fault_latched));
      clr();
      trip(n);
      chk("rearm_latch", 32'h0, 32'(fault_latched));
      clr();
    end
    wr(LFS_OFS_FAULT_SETUP, 32'h0002_8080);
    trip(n);
    n = 0;
    while (fault_output_pin_n !== 1'b1 && n < 41000) begin
      @(negedge clk);
      n++;
    end
    chk("retry_wait", 32'h1, 32'(n >= 40000 && n <= 40004));
    if (n >= 41000) begin
      wrap_up();
    end
    trip(n);
    chk("limit_latch", 32'h1, 32'(fault_latched));
    chk("limit_brake", 32'(LFS_BR_RECIRC), 32'(bridge_mode));
    clr();
  endtask : s_retry

  // A pulse shorter than the deglitch time is ignored; a long one trips.
  task automatic s_deglitch;
    int n;
    auto_retry_limit = 3'h0;
    wr(LFS_OFS_FAULT_SETUP, 32'h0000_0800);
    lock_over_limit = 1'b1;
    repeat (6) @(negedge clk);
    lock_over_limit = 1'b0;
    repeat (20) @(negedge clk);
    chk("glitch_pin", 32'h1, 32'(fault_output_pin_n));
    trip(n);
    chk("deg_time_ok", 32'h1, 32'(n >= 8));
    clr();
  endtask : s_deglitch

  // Main sequence: reset for 12 cycles, then every scenario.
  initial begin
    rst = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    lock_over_limit = 1'b0;
    fault_clear = 1'b0;
    auto_retry_limit = 3'h0;
    err_count = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    s_reset();
    s_fault_reg();
    s_speed();
    s_latch();
    s_report();
    s_disabled();
    s_retry();
    s_deglitch();
    // A second reset mid-run must clear every register again.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    s_reset();
    wrap_up();
  end

endmodule : tb
